/* pkg/phy_cfg_pkg.sv */
// Purpose: Constants for PHY digital/transmit configuration and LED combine
// Assumes: 125 MHz core clock, 5-bit management register addresses
// Notes: Stretch times are approximate nominal figures
`default_nettype none
package phy_cfg_pkg;
   // ==========================================
   // Register addresses
   localparam logic [4:0] ADDR_LED_CFG = 5'h14;
   localparam logic [4:0] ADDR_DIG_CFG = 5'h1a;
   localparam logic [4:0] ADDR_TX_CTL = 5'h1e;
   // ==========================================
   // Field positions
   localparam int DIG_DRIVE_BIT = 11;
   localparam int DIG_SYMERR_BIT = 9;
   localparam int TX_LOWPWR_BIT = 12;
   localparam int TX_RISE_LSB = 10;
   localparam int LED_STRETCH_EN_BIT = 1;
   localparam int LED_PERIOD_LSB = 2;
   localparam int LED3_LSB = 4;
   localparam int LED2_LSB = 8;
   localparam int LED1_LSB = 12;
   // ==========================================
   // Writable masks and reset values
   localparam logic [15:0] DIG_WMASK = 16'h0e00;
   localparam logic [15:0] TX_WMASK = 16'hffff;
   localparam logic [15:0] LED_WMASK = 16'hffff;
   localparam logic [15:0] DIG_RESET = 16'h0000;
   localparam logic [15:0] TX_RESET = 16'h0000;
   localparam logic [15:0] LED_RESET = 16'h0422;
   // ==========================================
   // LED mode codes
   typedef enum logic [3:0]
   {
      LED_LINK_RX = 4'b1100,
      LED_LINK_ACT = 4'b1101,
      LED_DPX_COL = 4'b1110,
      LED_OTHER = 4'b0000
   } led_mode_t;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int STRETCH0_MS = 30;
   localparam int STRETCH1_MS = 60;
   localparam int STRETCH2_MS = 100;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int STRETCH0_CYC = STRETCH0_MS * CYC_PER_MS;
   localparam int STRETCH1_CYC = STRETCH1_MS * CYC_PER_MS;
   localparam int STRETCH2_CYC = STRETCH2_MS * CYC_PER_MS;
endpackage
`default_nettype wire

/* rtl/phy_cfg_led_combine.sv */
// Purpose: Digital config, transmit control and combined-mode LED drivers
// Assumes: Management write strobe on sys_clk, reads decoded from regAddr; status from core logic
// Notes: Non-combined LED codes are served elsewhere; here LED is low
`timescale 1ns/100ps
`default_nettype none
module phy_cfg_led_combine #(
   parameter int NUM_LEDS = 3,
   parameter int STRETCH0 = phy_cfg_pkg::STRETCH0_CYC,
   parameter int STRETCH1 = phy_cfg_pkg::STRETCH1_CYC,
   parameter int STRETCH2 = phy_cfg_pkg::STRETCH2_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic regWrite,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   output logic [15:0] regRdData,
   input wire logic rxErrNormal,
   input wire logic symbolErr,
   input wire logic [1:0] txSymbol,
   output logic miiRxErr,
   output logic miiDriveHigh,
   output logic txLowPower,
   output logic [1:0] txLineSymbol,
   output logic [1:0] txRiseSelect,
   input wire logic linkUp,
   input wire logic fullDuplex,
   input wire logic rxEvent,
   input wire logic actEvent,
   input wire logic colEvent,
   output logic [NUM_LEDS-1:0] ledOn
);
   // Elaboration check of parameters
   generate
      if (NUM_LEDS < 1 || NUM_LEDS > 3 || STRETCH0 < 1 || STRETCH1 < 1
          || STRETCH2 < 1)
      begin : gBadParam
         $error("Unsupported parameter values");
      end
   endgenerate

   // ==========================================
   // Registers
   logic [15:0] digCfg_q, digCfg_d;
   logic [15:0] txCtl_q, txCtl_d;
   logic [15:0] ledCfg_q, ledCfg_d;

   always_comb
   begin
      digCfg_d = digCfg_q;
      txCtl_d = txCtl_q;
      ledCfg_d = ledCfg_q;
      if (regWrite)
      begin
         case (regAddr)
            phy_cfg_pkg::ADDR_DIG_CFG:
               digCfg_d = regWrData & phy_cfg_pkg::DIG_WMASK;
            phy_cfg_pkg::ADDR_TX_CTL:
               txCtl_d = regWrData & phy_cfg_pkg::TX_WMASK;
            phy_cfg_pkg::ADDR_LED_CFG:
               ledCfg_d = regWrData & phy_cfg_pkg::LED_WMASK;
            default:
               digCfg_d = digCfg_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         digCfg_q <= phy_cfg_pkg::DIG_RESET;
         txCtl_q <= phy_cfg_pkg::TX_RESET;
         ledCfg_q <= phy_cfg_pkg::LED_RESET;
      end
      else
      begin
         digCfg_q <= digCfg_d;
         txCtl_q <= txCtl_d;
         ledCfg_q <= ledCfg_d;
      end
   end

   always_comb
   begin
      case (regAddr)
         phy_cfg_pkg::ADDR_DIG_CFG: regRdData = digCfg_q;
         phy_cfg_pkg::ADDR_TX_CTL: regRdData = txCtl_q;
         phy_cfg_pkg::ADDR_LED_CFG: regRdData = ledCfg_q;
         default: regRdData = 16'h0000;
      endcase
   end

   // ==========================================
   // Datapath outputs
   logic miiRxErr_q, miiRxErr_d;
   logic [1:0] txLine_q, txLine_d;
   logic symErrEn, lowPwr;

   assign symErrEn = digCfg_q[phy_cfg_pkg::DIG_SYMERR_BIT];
   assign lowPwr = txCtl_q[phy_cfg_pkg::TX_LOWPWR_BIT];

   always_comb
   begin
      miiRxErr_d = symErrEn ? symbolErr : rxErrNormal;
      txLine_d = lowPwr ? 2'h0 : txSymbol;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         miiRxErr_q <= 1'b0;
         txLine_q <= 2'h0;
      end
      else
      begin
         miiRxErr_q <= miiRxErr_d;
         txLine_q <= txLine_d;
      end
   end

   assign miiRxErr = miiRxErr_q;
   assign txLineSymbol = txLine_q;
   assign miiDriveHigh = digCfg_q[phy_cfg_pkg::DIG_DRIVE_BIT];
   assign txLowPower = lowPwr;
   assign txRiseSelect = txCtl_q[phy_cfg_pkg::TX_RISE_LSB +: 2];

   // ==========================================
   // Status input synchronisers
   logic [4:0] syncA_q, syncB_q;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         syncA_q <= 5'h00;
         syncB_q <= 5'h00;
      end
      else
      begin
         syncA_q <= {linkUp, fullDuplex, rxEvent, actEvent, colEvent};
         syncB_q <= syncA_q;
      end
   end

   // ==========================================
   // Stretch period decode
   logic [1:0] periodSel;
   logic [31:0] stretchLen;

   assign periodSel = ledCfg_q[phy_cfg_pkg::LED_PERIOD_LSB +: 2];

   always_comb
   begin
      case (periodSel)
         2'b00: stretchLen = 32'(STRETCH0);
         2'b01: stretchLen = 32'(STRETCH1);
         2'b10: stretchLen = 32'(STRETCH2);
         default: stretchLen = 32'(STRETCH0);
      endcase
   end

   function automatic logic [3:0] ledCode(input logic [15:0] cfg,
                                          input int idx);
      logic [3:0] code;
      code = 4'h0;
      case (idx)
         0: code = cfg[phy_cfg_pkg::LED1_LSB +: 4];
         1: code = cfg[phy_cfg_pkg::LED2_LSB +: 4];
         default: code = cfg[phy_cfg_pkg::LED3_LSB +: 4];
      endcase
      return code;
   endfunction

   // ==========================================
   // Per-LED combine logic
   genvar g;
   generate
      for (g = 0; g < NUM_LEDS; g++)
      begin : gLed
         logic [31:0] cnt_q, cnt_d;
         logic led_q, led_d;
         logic primary, secondary, combined;
         logic [3:0] code;

         assign code = ledCode(ledCfg_q, g);

         always_comb
         begin
            combined = 1'b1;
            case (code)
               phy_cfg_pkg::LED_LINK_RX:
               begin
                  primary = syncB_q[4];
                  secondary = syncB_q[2];
               end
               phy_cfg_pkg::LED_LINK_ACT:
               begin
                  primary = syncB_q[4];
                  secondary = syncB_q[1];
               end
               phy_cfg_pkg::LED_DPX_COL:
               begin
                  primary = syncB_q[3];
                  secondary = syncB_q[0];
               end
               default:
               begin
                  primary = 1'b0;
                  secondary = 1'b0;
                  combined = 1'b0;
               end
            endcase
            if (!combined)
               cnt_d = 32'h0000_0000;
            else if (secondary)
               cnt_d = stretchLen;
            else if (cnt_q != 32'h0000_0000)
               cnt_d = cnt_q - 32'h0000_0001;
            else
               cnt_d = cnt_q;
            led_d = combined & (primary ^ (cnt_d != 32'h0000_0000));
         end

         always_ff @(posedge sys_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               cnt_q <= 32'h0000_0000;
               led_q <= 1'b0;
            end
            else
            begin
               cnt_q <= cnt_d;
               led_q <= led_d;
            end
         end

         assign ledOn[g] = led_q;
      end
   endgenerate
endmodule
`default_nettype wire

/* testbench/phy_cfg_led_chk.sv */
// Purpose: Port checker for the configuration block
// Assumes: One clock domain
// Notes: Bound from the bench
`timescale 1ns/100ps
`default_nettype none
module phy_cfg_led_chk (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic regWrite,
   input wire logic [4:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData,
   input wire logic rxErrNormal,
   input wire logic symbolErr,
   input wire logic [1:0] txSymbol,
   input wire logic miiRxErr,
   input wire logic miiDriveHigh,
   input wire logic txLowPower,
   input wire logic [1:0] txLineSymbol,
   input wire logic [1:0] txRiseSelect
);
   logic symSel_q;
   logic digWr;
   logic txWr;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   assign digWr = regWrite && regAddr == phy_cfg_pkg::ADDR_DIG_CFG;
   assign txWr = regWrite && regAddr == phy_cfg_pkg::ADDR_TX_CTL;
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
         symSel_q <= 1'b0;
      else if (digWr)
         symSel_q <= regWrData[9];
   // ==========================================
   // Assertions
   a_rxerr_route: assert property (
      $past(rst_b) |-> miiRxErr == ($past(symSel_q) ? $past(symbolErr)
      : $past(rxErrNormal))) else $error("receive error source wrong");
   a_drive_level: assert property (
      digWr |=> miiDriveHigh == $past(regWrData[11]))
      else $error("drive strength wrong");
   a_drive_hold: assert property (
      !digWr |=> $stable(miiDriveHigh)) else $error("drive level moved");
   a_lowpwr_level: assert property (
      txWr |=> txLowPower == $past(regWrData[12]))
      else $error("low power wrong");
   a_zero_diff: assert property (
      $past(rst_b) |-> txLineSymbol == ($past(txLowPower) ? 2'b00
      : $past(txSymbol))) else $error("line symbol wrong");
   a_rise_level: assert property (
      txWr |=> txRiseSelect == $past(regWrData[11:10]))
      else $error("rise select wrong");
   a_dig_reserved: assert property (
      regAddr == phy_cfg_pkg::ADDR_DIG_CFG |->
      (regRdData & 16'hf5ff) == 16'h0000) else $error("reserved bits set");
   a_tx_readback: assert property (
      txWr ##1 regAddr == phy_cfg_pkg::ADDR_TX_CTL |->
      regRdData == $past(regWrData)) else $error("readback wrong");
endmodule
`default_nettype wire

/* testbench/mac_side_model.sv */
// Purpose: Core side source of symbols and error flags
// Assumes: Same clock as the block
// Notes: Counter pattern keeps every line moving
`timescale 1ns/100ps
`default_nettype none
module mac_side_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   output logic [1:0] txSymbol,
   output logic rxErrNormal,
   output logic symbolErr
);
   logic [3:0] cnt_q;
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
         cnt_q <= 4'h0;
      else
         cnt_q <= cnt_q + 4'h1;
   assign txSymbol = cnt_q[1:0];
   assign rxErrNormal = cnt_q[2];
   assign symbolErr = cnt_q[3] ^ cnt_q[0];
endmodule
`default_nettype wire

/* testbench/tb_phy_cfg_led_combine.sv */
// Purpose: Register and LED tests for the configuration block
// Assumes: Short stretch counts 8/16/24
// Notes: Blink length allows a few cycles of sync lag
`timescale 1ns/100ps
`default_nettype none
module tb_phy_cfg_led_combine;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic regWrite = 1'b0;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData;
   logic rxErrNormal, symbolErr, miiRxErr, miiDriveHigh, txLowPower;
   logic [1:0] txSymbol, txLineSymbol, txRiseSelect;
   logic linkUp = 0, fullDuplex = 0, rxEvent = 0, actEvent = 0, colEvent = 0;
   logic [2:0] ledOn;
   int failCount = 0;
   int nTests = 0;
   phy_cfg_led_combine #(.STRETCH0(8), .STRETCH1(16), .STRETCH2(24)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .regWrite(regWrite),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .rxErrNormal(rxErrNormal), .symbolErr(symbolErr),
      .txSymbol(txSymbol), .miiRxErr(miiRxErr),
      .miiDriveHigh(miiDriveHigh), .txLowPower(txLowPower),
      .txLineSymbol(txLineSymbol), .txRiseSelect(txRiseSelect),
      .linkUp(linkUp), .fullDuplex(fullDuplex), .rxEvent(rxEvent),
      .actEvent(actEvent), .colEvent(colEvent), .ledOn(ledOn));
   mac_side_model mac (.sys_clk(sys_clk), .rst_b(rst_b),
      .txSymbol(txSymbol), .rxErrNormal(rxErrNormal),
      .symbolErr(symbolErr));
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] exp, got);
      nTests++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         failCount++;
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      regAddr <= a;
      #1 chk("read data", exp, regRdData);
   endtask
   task automatic rx_check(input logic s);
      logic b;
      logic [1:0] t;
      repeat (8)
      begin
         @(posedge sys_clk);
         b = s ? symbolErr : rxErrNormal;
         t = txSymbol;
         #1 chk("rx error", 16'(b), 16'(miiRxErr));
         chk("line", 16'(t), 16'(txLineSymbol));
      end
   endtask
   task automatic blink(input int i, k, input logic p, input int e);
      int n;
      n = 0;
      @(posedge sys_clk);
      {rxEvent, actEvent, colEvent} <= 3'(4 >> k);
      @(posedge sys_clk);
      {rxEvent, actEvent, colEvent} <= 3'b000;
      while (ledOn[i] === p && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      n = 0;
      while (ledOn[i] === !p && n < 99)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("blink length", 16'(e), 16'(n));
      chk("led level", 16'(p), 16'(ledOn[i]));
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(phy_cfg_pkg::ADDR_DIG_CFG, 16'h0000);
      rd(phy_cfg_pkg::ADDR_TX_CTL, 16'h0000);
      rd(phy_cfg_pkg::ADDR_LED_CFG, 16'h0422);
      rd(5'h03, 16'h0000);
      rx_check(1'b0);
      wr(phy_cfg_pkg::ADDR_DIG_CFG, 16'h0a00);
      rd(phy_cfg_pkg::ADDR_DIG_CFG, 16'h0a00);
      chk("drive", 16'h0001, 16'(miiDriveHigh));
      rx_check(1'b1);
      for (int c = 0; c < 4; c++)
      begin
         wr(phy_cfg_pkg::ADDR_TX_CTL, 16'(c) << 10);
         rd(phy_cfg_pkg::ADDR_TX_CTL, 16'(c) << 10);
         chk("rise", 16'(c), 16'(txRiseSelect));
      end
      wr(phy_cfg_pkg::ADDR_TX_CTL, 16'h1000);
      #1 chk("low power", 16'h0001, 16'(txLowPower));
      repeat (2) @(posedge sys_clk);
      #1 chk("line", 16'h0000, 16'(txLineSymbol));
      wr(phy_cfg_pkg::ADDR_TX_CTL, 16'h0000);
      for (int p = 0; p < 4; p++)
      begin
         wr(phy_cfg_pkg::ADDR_LED_CFG, 16'hd000 | (16'(p) << 2));
         blink(0, 1, 1'b0, p == 1 ? 16 : p == 2 ? 24 : 8);
      end
      linkUp <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("link led", 16'h0001, 16'(ledOn[0]));
      blink(0, 1, 1'b1, 8);
      wr(phy_cfg_pkg::ADDR_LED_CFG, 16'h00c0);
      blink(2, 0, 1'b1, 8);
      wr(phy_cfg_pkg::ADDR_LED_CFG, 16'h0e00);
      fullDuplex <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("duplex led", 16'h0001, 16'(ledOn[1]));
      blink(1, 2, 1'b1, 8);
      stop_test();
   end
endmodule
bind phy_cfg_led_combine phy_cfg_led_chk chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .regWrite(regWrite),
   .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
   .rxErrNormal(rxErrNormal), .symbolErr(symbolErr), .txSymbol(txSymbol),
   .miiRxErr(miiRxErr), .miiDriveHigh(miiDriveHigh),
   .txLowPower(txLowPower), .txLineSymbol(txLineSymbol),
   .txRiseSelect(txRiseSelect));
`default_nettype wire
